/* verilog/dpwm_cfg.svh */
// register map, field positions, reset values and constants of the dual pwm block
`ifndef DPWM_CFG_SVH
`define DPWM_CFG_SVH

// printed offsets are register indices; byte address is four times the index
`define DPWM_IDX_FINE_A 16'h7FAA
`define DPWM_IDX_COARSE_A 16'h7FAB
`define DPWM_IDX_FINE_B 16'h7FAC
`define DPWM_IDX_COARSE_B 16'h7FAD
`define DPWM_IDX_CONTROL 16'h7FAE
`define DPWM_IDX_PRESCALE 16'h7FAF
`define DPWM_IDX_PORT_CFG 16'h7FB0
`define DPWM_IDX_TIMER_SRC 16'h7FB6

// address fields
`define DPWM_ADDR_IDX_HI 17
`define DPWM_ADDR_IDX_LO 2
`define DPWM_ADDR_TOP_HI 31
`define DPWM_ADDR_TOP_LO 18
`define DPWM_ADDR_TOP_ZERO 14'h0000

// control register fields
`define DPWM_CTL_IE 0
`define DPWM_CTL_OV 1
`define DPWM_CTL_EN_A 2
`define DPWM_CTL_EN_B 3
`define DPWM_CTL_CH_HI 7
`define DPWM_CTL_CH_LO 4

// fine compare field
`define DPWM_FINE_HI 7
`define DPWM_FINE_LO 4

// timer source register fields
`define DPWM_TSRC_SEL 0
`define DPWM_TSRC_OTHER_HI 7
`define DPWM_TSRC_OTHER_LO 2

// port config: per output function, fast/slow, latch, direction
`define DPWM_PCFG_B_LO 4
`define DPWM_PCFG_DDR 0
`define DPWM_PCFG_LAT 1
`define DPWM_PCFG_FSB 2
`define DPWM_PCFG_FSA 3

// reset values and constants
`define DPWM_RST_BYTE 8'h00
`define DPWM_RST_NIB 4'h0
`define DPWM_RST_SIX 6'h00
`define DPWM_RST_IDX 16'h0000
`define DPWM_RST_WORD 32'h00000000
`define DPWM_NIB_ONES 4'hF
`define DPWM_NIB_ZERO 4'h0
`define DPWM_BYTE_ZERO 8'h00
`define DPWM_BYTE_ONE 8'h01
`define DPWM_NIB_ONE 4'h1
`define DPWM_HRESP_OKAY 1'b0

`endif

/* verilog/dpwm_pkg.sv */
// types of the dual pwm block
package dpwm_pkg;

    typedef struct packed {
        logic [3:0] fine_a;
        logic [7:0] coarse_a;
        logic [3:0] fine_b;
        logic [7:0] coarse_b;
        logic [3:0] base_period_field;
        logic run_enable_b;
        logic run_enable_a;
        logic cycle_done_flag;
        logic irq_enable_bit;
        logic [7:0] prescale_divider;
        logic [5:0] other_prescale_field;
        logic prescale_source_bit;
        logic [7:0] port_cfg;
        logic [7:0] psc_cnt;
        logic [7:0] base_cnt;
        logic [3:0] addl_cnt;
        logic [7:0] shadow_a;
        logic [7:0] shadow_b;
        logic osc_q;
        logic modulator_out_a;
        logic modulator_out_b;
        logic pin_a;
        logic pin_a_oe;
        logic pin_b;
        logic pin_b_oe;
        logic irq;
        logic wr_pend;
        logic [15:0] wr_idx;
        logic [31:0] hrdata;
        logic hreadyout;
    } dpwm_state_t;

endpackage

/* verilog/dpwm_top.sv */
// dual output 12-bit pwm generator with ahb-lite register slave
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "dpwm_cfg.svh"

module dpwm_top
    import dpwm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic fast_oscillator_clock,
    output logic modulator_out_a,
    output logic modulator_out_b,
    output logic pin_a_out,
    output logic pin_a_oe,
    output logic pin_b_out,
    output logic pin_b_oe,
    output logic irq
);

    dpwm_state_t st_r;
    dpwm_state_t st_nxt;

    function automatic logic [3:0] rev4(input logic [3:0] v);
        rev4 = {v[0], v[1], v[2], v[3]};
    endfunction

    // level of one output for the count value about to be held
    function automatic logic pwm_level(
        input logic run,
        input logic [7:0] cnt,
        input logic [7:0] shadow,
        input logic [3:0] fine,
        input logic [3:0] idx
    );
        logic extra;
        logic [8:0] width;
        extra = 1'b0;
        width = 9'h000;
        extra = (rev4(idx) < fine);
        width = {1'b0, shadow} + {8'h00, extra};
        // counting from zero, cnt < width is high from period start to compare match
        pwm_level = run & ({1'b0, cnt} < width);
    endfunction

    // pin drive: returns {out, oe}
    function automatic logic [1:0] pin_drive(
        input logic level,
        input logic [3:0] cfg
    );
        logic inv;
        logic od;
        inv = 1'b0;
        od = 1'b0;
        inv = cfg[`DPWM_PCFG_LAT] & ~cfg[`DPWM_PCFG_DDR];
        od = cfg[`DPWM_PCFG_FSB] & ~cfg[`DPWM_PCFG_LAT] & cfg[`DPWM_PCFG_DDR];
        if (!cfg[`DPWM_PCFG_FSA]) begin
            pin_drive = 2'b00;
        end else if (od) begin
            // open drain only pulls low, released while high
            pin_drive = {1'b0, ~level};
        end else begin
            pin_drive = {level ^ inv, 1'b1};
        end
    endfunction

    logic [15:0] a_idx;
    logic a_top_ok;
    logic a_take;
    logic running;
    logic src_en;
    logic tick;
    logic eop;
    logic [7:0] limit;
    logic [7:0] wb;
    logic [1:0] drv_a;
    logic [1:0] drv_b;

    always_comb begin
        st_nxt = st_r;
        a_idx = haddr[`DPWM_ADDR_IDX_HI:`DPWM_ADDR_IDX_LO];
        a_top_ok = (haddr[`DPWM_ADDR_TOP_HI:`DPWM_ADDR_TOP_LO] == `DPWM_ADDR_TOP_ZERO);
        a_take = hsel & hready & htrans[1];
        wb = hwdata[7:0];
        tick = 1'b0;
        eop = 1'b0;
        limit = {st_r.base_period_field, `DPWM_NIB_ONES};
        drv_a = 2'b00;
        drv_b = 2'b00;

        // register write in the data phase
        if (st_r.wr_pend) begin
            case (st_r.wr_idx)
                `DPWM_IDX_FINE_A: begin
                    st_nxt.fine_a = wb[`DPWM_FINE_HI:`DPWM_FINE_LO];
                end
                `DPWM_IDX_COARSE_A: begin
                    st_nxt.coarse_a = wb;
                end
                `DPWM_IDX_FINE_B: begin
                    st_nxt.fine_b = wb[`DPWM_FINE_HI:`DPWM_FINE_LO];
                end
                `DPWM_IDX_COARSE_B: begin
                    st_nxt.coarse_b = wb;
                end
                `DPWM_IDX_CONTROL: begin
                    st_nxt.base_period_field = wb[`DPWM_CTL_CH_HI:`DPWM_CTL_CH_LO];
                    st_nxt.run_enable_b = wb[`DPWM_CTL_EN_B];
                    st_nxt.run_enable_a = wb[`DPWM_CTL_EN_A];
                    st_nxt.irq_enable_bit = wb[`DPWM_CTL_IE];
                    // writing zero clears the flag, writing one leaves it
                    st_nxt.cycle_done_flag = st_r.cycle_done_flag & wb[`DPWM_CTL_OV];
                end
                `DPWM_IDX_PRESCALE: begin
                    st_nxt.prescale_divider = wb;
                end
                `DPWM_IDX_PORT_CFG: begin
                    st_nxt.port_cfg = wb;
                end
                `DPWM_IDX_TIMER_SRC: begin
                    // no interlock: a change while running just retimes the next tick
                    st_nxt.prescale_source_bit = wb[`DPWM_TSRC_SEL];
                    st_nxt.other_prescale_field =
                        wb[`DPWM_TSRC_OTHER_HI:`DPWM_TSRC_OTHER_LO];
                end
                default: begin
                end
            endcase
        end

        // the oscillator pin is sampled as a synchronous input; rising edge is the count
        st_nxt.osc_q = fast_oscillator_clock;
        // no synchroniser: the pin must already be clean and slower than half hclk
        if (st_r.prescale_source_bit) begin
            src_en = fast_oscillator_clock & ~st_r.osc_q;
        end else begin
            src_en = 1'b1;
        end
        running = st_r.run_enable_a | st_r.run_enable_b;

        // prescaler
        if (!running) begin
            st_nxt.psc_cnt = `DPWM_BYTE_ZERO;
        end else if (src_en) begin
            if (st_r.psc_cnt == st_r.prescale_divider) begin
                st_nxt.psc_cnt = `DPWM_BYTE_ZERO;
                tick = 1'b1;
            end else begin
                st_nxt.psc_cnt = st_r.psc_cnt + `DPWM_BYTE_ONE;
            end
        end

        // base counter
        if (!running) begin
            st_nxt.base_cnt = `DPWM_BYTE_ZERO;
        end else if (tick) begin
            if (st_r.base_cnt == limit) begin
                st_nxt.base_cnt = `DPWM_BYTE_ZERO;
                eop = 1'b1;
            end else begin
                st_nxt.base_cnt = st_r.base_cnt + `DPWM_BYTE_ONE;
            end
        end

        // extra-pulse counter and overall period flag; set beats a clearing write
        if (eop) begin
            st_nxt.addl_cnt = st_r.addl_cnt + `DPWM_NIB_ONE;
            if (st_r.addl_cnt == `DPWM_NIB_ONES) begin
                st_nxt.cycle_done_flag = 1'b1;
            end
        end

        // shadow compares
        if (!st_r.run_enable_a) begin
            st_nxt.shadow_a = st_nxt.coarse_a;
        end else if (st_nxt.base_cnt == `DPWM_BYTE_ZERO) begin
            st_nxt.shadow_a = st_nxt.coarse_a;
        end
        if (!st_r.run_enable_b) begin
            st_nxt.shadow_b = st_nxt.coarse_b;
        end else if (st_nxt.base_cnt == `DPWM_BYTE_ZERO) begin
            st_nxt.shadow_b = st_nxt.coarse_b;
        end

        // outputs follow the next count so they sit directly on flops
        // the enable edge itself stays low, so the first pulse after a start is one hclk short
        st_nxt.modulator_out_a = pwm_level(
            st_nxt.run_enable_a & st_r.run_enable_a,
            st_nxt.base_cnt,
            st_nxt.shadow_a,
            st_nxt.fine_a,
            st_nxt.addl_cnt
        );
        st_nxt.modulator_out_b = pwm_level(
            st_nxt.run_enable_b & st_r.run_enable_b,
            st_nxt.base_cnt,
            st_nxt.shadow_b,
            st_nxt.fine_b,
            st_nxt.addl_cnt
        );
        // pads follow the same next level, so pin and raw output never skew
        drv_a = pin_drive(
            st_nxt.modulator_out_a,
            st_nxt.port_cfg[3:0]
        );
        drv_b = pin_drive(
            st_nxt.modulator_out_b,
            st_nxt.port_cfg[`DPWM_PCFG_B_LO+3:`DPWM_PCFG_B_LO]
        );
        st_nxt.pin_a = drv_a[1];
        st_nxt.pin_a_oe = drv_a[0];
        st_nxt.pin_b = drv_b[1];
        st_nxt.pin_b_oe = drv_b[0];

        st_nxt.irq = st_nxt.cycle_done_flag & st_nxt.irq_enable_bit;

        // address phase: capture write, prepare read data from updated state
        st_nxt.wr_pend = a_take & hwrite & a_top_ok;
        st_nxt.wr_idx = a_idx;
        if (a_take & ~hwrite) begin
            st_nxt.hrdata = `DPWM_RST_WORD;
            if (a_top_ok) begin
                case (a_idx)
                    `DPWM_IDX_FINE_A: begin
                        st_nxt.hrdata[7:0] = {st_nxt.fine_a, `DPWM_NIB_ZERO};
                    end
                    `DPWM_IDX_COARSE_A: begin
                        st_nxt.hrdata[7:0] = st_nxt.coarse_a;
                    end
                    `DPWM_IDX_FINE_B: begin
                        st_nxt.hrdata[7:0] = {st_nxt.fine_b, `DPWM_NIB_ZERO};
                    end
                    `DPWM_IDX_COARSE_B: begin
                        st_nxt.hrdata[7:0] = st_nxt.coarse_b;
                    end
                    `DPWM_IDX_CONTROL: begin
                        // next-state view: a read right after a write sees the new value
                        st_nxt.hrdata[7:0] = {
                            st_nxt.base_period_field,
                            st_nxt.run_enable_b,
                            st_nxt.run_enable_a,
                            st_nxt.cycle_done_flag,
                            st_nxt.irq_enable_bit
                        };
                    end
                    `DPWM_IDX_PRESCALE: begin
                        st_nxt.hrdata[7:0] = st_nxt.prescale_divider;
                    end
                    `DPWM_IDX_PORT_CFG: begin
                        st_nxt.hrdata[7:0] = st_nxt.port_cfg;
                    end
                    `DPWM_IDX_TIMER_SRC: begin
                        st_nxt.hrdata[7:0] = {
                            st_nxt.other_prescale_field,
                            1'b0,
                            st_nxt.prescale_source_bit
                        };
                    end
                    default: begin
                    end
                endcase
            end
        end
        st_nxt.hreadyout = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r.fine_a <= `DPWM_RST_NIB;
            st_r.coarse_a <= `DPWM_RST_BYTE;
            st_r.fine_b <= `DPWM_RST_NIB;
            st_r.coarse_b <= `DPWM_RST_BYTE;
            st_r.base_period_field <= `DPWM_RST_NIB;
            st_r.run_enable_b <= 1'b0;
            st_r.run_enable_a <= 1'b0;
            st_r.cycle_done_flag <= 1'b0;
            st_r.irq_enable_bit <= 1'b0;
            st_r.prescale_divider <= `DPWM_RST_BYTE;
            st_r.other_prescale_field <= `DPWM_RST_SIX;
            st_r.prescale_source_bit <= 1'b0;
            st_r.port_cfg <= `DPWM_RST_BYTE;
            st_r.psc_cnt <= `DPWM_RST_BYTE;
            st_r.base_cnt <= `DPWM_RST_BYTE;
            st_r.addl_cnt <= `DPWM_RST_NIB;
            st_r.shadow_a <= `DPWM_RST_BYTE;
            st_r.shadow_b <= `DPWM_RST_BYTE;
            st_r.osc_q <= 1'b0;
            st_r.modulator_out_a <= 1'b0;
            st_r.modulator_out_b <= 1'b0;
            st_r.pin_a <= 1'b0;
            st_r.pin_a_oe <= 1'b0;
            st_r.pin_b <= 1'b0;
            st_r.pin_b_oe <= 1'b0;
            st_r.irq <= 1'b0;
            st_r.wr_pend <= 1'b0;
            st_r.wr_idx <= `DPWM_RST_IDX;
            st_r.hrdata <= `DPWM_RST_WORD;
            st_r.hreadyout <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hreadyout = st_r.hreadyout;
    assign hresp = `DPWM_HRESP_OKAY;
    assign hrdata = st_r.hrdata;
    assign modulator_out_a = st_r.modulator_out_a;
    assign modulator_out_b = st_r.modulator_out_b;
    assign pin_a_out = st_r.pin_a;
    assign pin_a_oe = st_r.pin_a_oe;
    assign pin_b_out = st_r.pin_b;
    assign pin_b_oe = st_r.pin_b_oe;
    assign irq = st_r.irq;

endmodule

/* verification/dpwm_top_chk.sv */
// port-level assertions for the dual pwm block
`timescale 1ns/1ps
`include "dpwm_cfg.svh"

module dpwm_top_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic modulator_out_a,
    input wire logic modulator_out_b,
    input wire logic irq
);
    // mirror of the control register, kept from bus traffic since it is not a port
    logic ph_r;
    logic wr_r;
    logic [15:0] idx_r;
    logic [7:0] ctl_r;
    wire wr_ctl = ph_r && wr_r && idx_r == `DPWM_IDX_CONTROL;
    wire rd_ph = ph_r && !wr_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_r <= 1'b0;
            wr_r <= 1'b0;
            idx_r <= 16'h0000;
            ctl_r <= 8'h00;
        end else begin
            ph_r <= hsel && hready && htrans[1];
            wr_r <= hwrite;
            idx_r <= (haddr[31:18] == 14'h0000) ? haddr[17:2] : 16'h0000;
            if (wr_ctl) begin
                ctl_r <= hwdata[7:0];
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("slave inserted a wait state");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave answered with an error response");
    a_rdata_top: assert property (rd_ph |-> hrdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
    a_fine_low: assert property (rd_ph && (idx_r == `DPWM_IDX_FINE_A ||
        idx_r == `DPWM_IDX_FINE_B) |-> hrdata[3:0] == 4'h0)
        else $error("fine register low nibble read nonzero");
    a_tsrc_bit1: assert property (rd_ph && idx_r == `DPWM_IDX_TIMER_SRC |-> !hrdata[1])
        else $error("timer source bit 1 read as one");
    // one cycle of slack: the output flop already takes the new enable on the write edge
    a_stop_low_a: assert property (!ctl_r[2] && !$past(ctl_r[2]) |-> !modulator_out_a)
        else $error("stopped output a not low");
    a_stop_low_b: assert property (!ctl_r[3] && !$past(ctl_r[3]) |-> !modulator_out_b)
        else $error("stopped output b not low");
    a_irq_gate: assert property (!ctl_r[0] && !$past(ctl_r[0]) |-> !irq)
        else $error("interrupt raised while disabled");
    // enable write and irq flop update land on one edge, so look at the enable now
    a_irq_rise: assert property ($rose(irq) |-> ctl_r[0])
        else $error("interrupt rose without enable");
    a_irq_sticky: assert property (irq && !wr_ctl && !$past(wr_ctl) |=> irq)
        else $error("overflow dropped without a clearing write");
endmodule

bind dpwm_top dpwm_top_chk u_dpwm_top_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .modulator_out_a(modulator_out_a),
    .modulator_out_b(modulator_out_b), .irq(irq)
);

/* verification/tb_dpwm_top.sv */
// self-checking bench for the dual pwm block
`timescale 1ns/1ps
`include "dpwm_cfg.svh"

module tb_dpwm_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic [3:0] osc_r = 4'h0;
    logic hreadyout, hresp, irq, out_a, out_b, pin_a, pin_a_oe, pin_b, pin_b_oe;
    logic [31:0] hrdata;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;

    dpwm_top u_dpwm_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .fast_oscillator_clock(osc_r[1]), .modulator_out_a(out_a), .modulator_out_b(out_b),
        .pin_a_out(pin_a), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b), .pin_b_oe(pin_b_oe),
        .irq(irq)
    );

    always #10 hclk = ~hclk;

    // oscillator rises once every four system clocks; cycles by nba so reads see one value
    always @(posedge hclk) begin
        osc_r <= osc_r + 4'h1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d,
            output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {14'h0000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(q, exp);
    endtask

    // a window of whole overall periods makes the counts independent of phase
    task automatic meas(input int n, output int ha, output int hb, output int ra);
        logic pa_q;
        ha = 0;
        hb = 0;
        ra = 0;
        pa_q = out_a;
        repeat (n) begin
            @(posedge hclk);
            if (out_a === 1'b1) ha++;
            if (out_b === 1'b1) hb++;
            if (out_a === 1'b1 && pa_q !== 1'b1) ra++;
            pa_q = out_a;
        end
    endtask

    task automatic t_regs();
        logic [15:0] map [8] = '{`DPWM_IDX_FINE_A, `DPWM_IDX_COARSE_A, `DPWM_IDX_FINE_B,
            `DPWM_IDX_COARSE_B, `DPWM_IDX_CONTROL, `DPWM_IDX_PRESCALE, `DPWM_IDX_PORT_CFG,
            `DPWM_IDX_TIMER_SRC};
        foreach (map[i]) rd(map[i], 32'h00000000);
        wr(`DPWM_IDX_FINE_A, 8'hFF);
        rd(`DPWM_IDX_FINE_A, 32'h000000F0);
        wr(`DPWM_IDX_FINE_B, 8'h5A);
        rd(`DPWM_IDX_FINE_B, 32'h00000050);
        wr(`DPWM_IDX_COARSE_B, 8'h3C);
        rd(`DPWM_IDX_COARSE_B, 32'h0000003C);
        wr(`DPWM_IDX_PRESCALE, 8'h81);
        rd(`DPWM_IDX_PRESCALE, 32'h00000081);
        wr(`DPWM_IDX_TIMER_SRC, 8'hFF);
        rd(`DPWM_IDX_TIMER_SRC, 32'h000000FD);
        wr(`DPWM_IDX_TIMER_SRC, 8'h00);
        wr(16'h7FB1, 8'hFF);
        rd(16'h7FB1, 32'h00000000);
    endtask

    task automatic t_pwm(input logic [7:0] dv, input logic [3:0] fld, input logic [7:0] c,
            input logic [3:0] f, input int n);
        int ha, hb, ra;
        wr(`DPWM_IDX_CONTROL, 8'h00);
        wr(`DPWM_IDX_PRESCALE, dv);
        wr(`DPWM_IDX_COARSE_A, c);
        wr(`DPWM_IDX_COARSE_B, c + 8'h01);
        wr(`DPWM_IDX_FINE_A, {f, 4'h0});
        wr(`DPWM_IDX_FINE_B, {~f, 4'h0});
        wr(`DPWM_IDX_CONTROL, {fld, 4'hC});
        repeat (n) @(posedge hclk);
        meas(n, ha, hb, ra);
        chk(ha, (dv + 1) * (16 * c + f));
        chk(hb, (dv + 1) * (16 * (c + 1) + 15 - f));
        chk(ra, (c != 0) ? 16 : f);
    endtask

    task automatic t_osc();
        int ha, hb, ra;
        wr(`DPWM_IDX_CONTROL, 8'h00);
        wr(`DPWM_IDX_TIMER_SRC, 8'h01);
        wr(`DPWM_IDX_PRESCALE, 8'h00);
        wr(`DPWM_IDX_COARSE_A, 8'h02);
        wr(`DPWM_IDX_FINE_A, 8'h00);
        wr(`DPWM_IDX_CONTROL, 8'h04);
        repeat (1024) @(posedge hclk);
        meas(1024, ha, hb, ra);
        chk(ha, 32'h00000080);
        chk(hb, 32'h00000000);
        wr(`DPWM_IDX_CONTROL, 8'h00);
        wr(`DPWM_IDX_TIMER_SRC, 8'h00);
    endtask

    task automatic t_pins();
        logic [3:0] cf [5] = '{4'hA, 4'h9, 4'hE, 4'hD, 4'h0};
        logic [1:0] ex [5] = '{2'h3, 2'h1, 2'h3, 2'h1, 2'h0};
        foreach (cf[i]) begin
            wr(`DPWM_IDX_PORT_CFG, {cf[i], cf[i]});
            repeat (2) @(posedge hclk);
            chk({pin_a & pin_a_oe, pin_a_oe, pin_b & pin_b_oe, pin_b_oe}, {ex[i], ex[i]});
        end
    endtask

    task automatic wait_irq();
        int n = 0;
        while (irq !== 1'b1 && n < 600) begin
            @(posedge hclk);
            n++;
        end
        chk(irq, 32'h00000001);
    endtask

    task automatic t_irq();
        int t0;
        wr(`DPWM_IDX_CONTROL, 8'h00);
        wr(`DPWM_IDX_CONTROL, 8'h05);
        wait_irq();
        t0 = cycles;
        rd(`DPWM_IDX_CONTROL, 32'h00000007);
        wr(`DPWM_IDX_CONTROL, 8'h05);
        repeat (2) @(posedge hclk);
        chk(irq, 32'h00000000);
        wait_irq();
        chk(cycles - t0, 32'h00000100);
        wr(`DPWM_IDX_CONTROL, 8'h04);
        repeat (300) @(posedge hclk);
        chk(irq, 32'h00000000);
        rd(`DPWM_IDX_CONTROL, 32'h00000006);
        wr(`DPWM_IDX_CONTROL, 8'h08);
        repeat (40) @(posedge hclk);
        chk(out_a, 32'h00000000);
        wr(`DPWM_IDX_CONTROL, 8'h00);
    endtask

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_pwm(8'h00, 4'h0, 8'h02, 4'h0, 256);
        t_pwm(8'h00, 4'h0, 8'h02, 4'h5, 256);
        t_pwm(8'h01, 4'h1, 8'h03, 4'hF, 1024);
        t_pwm(8'h00, 4'h2, 8'h00, 4'h9, 768);
        t_pwm(8'h00, 4'h0, 8'h0E, 4'h1, 256);
        t_osc();
        t_pins();
        t_irq();
        stop_test();
    end
endmodule
